// ---- rtl/mfs_axis.sv ----
// one manual feed axis: jog, incremental step, reference approach
`timescale 1ns/10ps
module mfs_axis (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_tick,
	input  wire logic        i_jog,
	input  wire logic        i_inc,
	input  wire logic        i_zrn,
	input  wire logic        i_plus,
	input  wire logic        i_minus,
	input  wire logic        i_rapid,
	input  wire logic        i_decel,
	input  wire logic        i_ref_dir,
	input  wire logic [10:0] i_step_len,
	output logic             o_run,
	output logic             o_dir,
	output logic [7:0]       o_rate,
	output logic [10:0]      o_left
);
	import mfs_pkg::*;
	`include "mfs_consts.svh"
	mfs_axis_type q;
	mfs_axis_type next_q;
	logic         sel;
	logic [7:0]   tgt;
	// motion state; a step once started runs to its end unless the method leaves incremental
	always_comb begin
		next_q         = q;
		sel            = i_plus | i_minus;
		next_q.sel_q   = sel;
		next_q.rapid_q = i_rapid;
		tgt = i_rapid ? `MFS_RAPID_RATE : `MFS_JOG_RATE;
		if (i_zrn && i_decel) tgt = `MFS_APPR_RATE;
		case (q.st)
			MFS_AX_IDLE: begin
				next_q.rate = '0;
				if ((i_jog || i_zrn) && sel) begin
					next_q.st   = MFS_AX_RUN;
					next_q.dir  = i_zrn ? i_ref_dir : i_plus;
					next_q.rate = tgt;
				end else if (i_inc && sel && !q.sel_q) begin
					next_q.st   = MFS_AX_RUN;
					next_q.dir  = i_plus;
					next_q.left = i_step_len;
					next_q.rate = tgt;
				end
			end
			MFS_AX_RUN: begin
				next_q.rate = tgt;
				if (!i_zrn && (i_rapid != q.rapid_q)) begin
					next_q.st   = MFS_AX_RAMP;
					next_q.rate = q.rate;
				end else if (i_inc) begin
					// select line is not looked at here
					if (i_tick) next_q.left = q.left - 11'h001;
					if (i_tick && q.left <= 11'h001) begin
						next_q.st   = MFS_AX_IDLE;
						next_q.rate = '0;
					end
				end else if (!((i_jog || i_zrn) && sel)) begin
					next_q.st   = MFS_AX_IDLE;
					next_q.rate = '0;
				end
			end
			MFS_AX_RAMP: begin
				// select may stay held through the ramp
				if (q.rate > `MFS_RAMP_DEC) begin
					next_q.rate = q.rate - `MFS_RAMP_DEC;
				end else begin
					next_q.rate = '0;
					if ((i_inc && q.left != '0) || (i_jog && sel))
						next_q.st = MFS_AX_RUN;
					else
						next_q.st = MFS_AX_IDLE;
				end
			end
			default: next_q.st = MFS_AX_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) q <= '0;
		else       q <= next_q;
	end
	// state bit 0 is high in run and ramp, so run is a bare flop
	assign o_run  = q.st[0];
	assign o_dir  = q.dir;
	assign o_rate = q.rate;
	assign o_left = q.left;
endmodule : mfs_axis

// ---- rtl/mfs_manual_feed.sv ----
// manual feed and status flag logic, top level
`timescale 1ns/10ps
// constants are needed by the parameter default, ahead of the header
`include "mfs_consts.svh"

// Operation
// - method reported one-hot in flag byte
// - cutting flag set during automatic cutting feed
// - cutting flag low while feed in dwell
// - cutting flag stays on at interlock, zero feedrate
// - per-axis plus and minus select bits
// - jog moves axis while select held
// - incremental moves one step per press
// - started step finishes after select drops
// - step is increment times ten, hundred, thousand
// - rapid select gives rapid rate, rapid override
// - rapid change ramps feedrate to zero, except in reference return
// - two-bit handwheel and single-step amount decode
// - reference return direction from axis parameter
// - end flag set after manual return in-position
// - end flag set after automatic return
// - end flag set after return check
// - end flag cleared off position, stop, alarm
// - decel input slows reference approach
module mfs_manual_feed #(
	parameter logic [7:0] TICK_DIV = `MFS_TICK_DIV
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire mfs_pkg::mfs_method_type i_method,
	input  wire logic [5:0]             i_feed_kind,
	input  wire logic                   i_dwell,
	input  wire logic                   i_interlock,
	input  wire mfs_pkg::mfs_panel_type  i_panel,
	input  wire mfs_pkg::mfs_ref_ev_type i_ref_ev,
	input  wire logic [4:0]             i_ref_dir,
	input  wire logic                   i_estop,
	input  wire logic                   i_servo_alarm,
	output logic [7:0]                  o_method_flags,
	output logic [7:0]                  o_cut_state,
	output logic [7:0]                  o_ref_end,
	output logic [9:0]                  o_hw_amount,
	output logic                        o_rapid_ovr_sel,
	output logic [3:0]                  o_axis_run,
	output logic [3:0]                  o_axis_dir,
	output logic [31:0]                 o_axis_rate
);
	import mfs_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mfs_top_type       q;
	mfs_top_type       next_q;
	mfs_panel_type     pan;
	logic [10:0]       step_len;
	logic [3:0][10:0]  left_w;
	logic [4:0]        ref_set;
	logic [4:0]        ref_clr;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	// PLC bytes are scanned asynchronously to this clock
	mfs_sync u_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (i_panel),
		.o_q   (pan)
	);

	// ----------------------------------------------------------------
	// step length select
	// ----------------------------------------------------------------
	// lowest set bit wins; nothing set falls back to x10
	always_comb begin
		step_len = `MFS_STEP_X10;
		if (pan.step_amount_select[0])
			step_len = `MFS_STEP_X10;
		else if (pan.step_amount_select[1])
			step_len = `MFS_STEP_X100;
		else if (pan.step_amount_select[2])
			step_len = `MFS_STEP_X1000;
	end

	// ----------------------------------------------------------------
	// reference end flag terms
	// ----------------------------------------------------------------
	// clear beats set: a stop must never leave a stale end flag
	assign ref_set = (i_ref_ev.manual_done | i_ref_ev.auto_done
		| i_ref_ev.check_done) & i_ref_ev.in_pos;
	assign ref_clr = i_ref_ev.off_ref
		| {5{i_estop | i_servo_alarm}};

	// ----------------------------------------------------------------
	// status state, next value
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		// all flag bytes come from one register edge
		next_q.operation_method_flags =
			`MFS_ONE_HOT << i_method;
		next_q.cutting_feed_state = '0;
		// interlock and zero feedrate do not drop the flag
		next_q.cutting_feed_state[`MFS_CUT_BIT] =
			(|i_feed_kind) & ~i_dwell;
		next_q.ref_return_end_flags[4:0] =
			(q.ref_return_end_flags[4:0] | ref_set)
			& ~ref_clr;
		next_q.ref_return_end_flags[7:5] = '0;
		next_q.rapid_sel =
			pan.rapid_select_byte[`MFS_RAPID_BIT];
		// handwheel and single-step amount decode
		case (pan.step_amount_select[5:4])
			2'b00:   next_q.hw_amt = `MFS_AMT_1;
			2'b01:   next_q.hw_amt = `MFS_AMT_10;
			2'b10:   next_q.hw_amt = `MFS_AMT_100;
			2'b11:   next_q.hw_amt =
				q.operation_method_flags[`MFS_HW_BIT]
				? `MFS_AMT_100 : `MFS_AMT_1000;
			default: next_q.hw_amt = `MFS_AMT_1;
		endcase
		// distance tick divider for incremental steps
		next_q.tick = 1'b0;
		if (q.div >= TICK_DIV - 8'h01) begin
			next_q.div  = '0;
			next_q.tick = 1'b1;
		end else begin
			next_q.div = q.div + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// status state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) q <= '0;
		else       q <= next_q;
	end

	assign o_method_flags  = q.operation_method_flags;
	assign o_cut_state     = q.cutting_feed_state;
	assign o_ref_end       = q.ref_return_end_flags;
	assign o_hw_amount     = q.hw_amt;
	assign o_rapid_ovr_sel = q.rapid_sel;

	// ----------------------------------------------------------------
	// axis engines
	// ----------------------------------------------------------------
	// modes come from the reported flags so motion matches them
	for (genvar a = 0; a < 4; a++) begin : g_axis
		mfs_axis u_axis (
			.i_clk      (i_clk),
			.i_rst      (i_rst),
			.i_tick     (q.tick),
			.i_jog      (q.operation_method_flags[`MFS_JOG_BIT]),
			.i_inc      (q.operation_method_flags[`MFS_INC_BIT]),
			.i_zrn      (q.operation_method_flags[`MFS_ZRN_BIT]),
			.i_plus     (pan.plus_direction_select[a]),
			.i_minus    (pan.minus_direction_select[a]),
			.i_rapid    (pan.rapid_select_byte[`MFS_RAPID_BIT]),
			.i_decel    (pan.decel_byte[a]),
			.i_ref_dir  (i_ref_dir[a]),
			.i_step_len (step_len),
			.o_run      (o_axis_run[a]),
			.o_dir      (o_axis_dir[a]),
			.o_rate     (o_axis_rate[a*8 +: 8]),
			.o_left     (left_w[a])
		);
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	method_onehot_a: assert property (
		!$past(i_rst) |-> o_method_flags ==
			(`MFS_ONE_HOT << $past(i_method)))
		else $error("method flags not one-hot of method");

	cut_set_a: assert property (
		(|i_feed_kind && !i_dwell) |=> o_cut_state[`MFS_CUT_BIT])
		else $error("cutting flag missing during cutting");

	cut_dwell_a: assert property (
		i_dwell |=> o_cut_state == 8'h00)
		else $error("cutting flag set during dwell");

	cut_lock_a: assert property (
		(|i_feed_kind && !i_dwell && i_interlock)
			|=> o_cut_state[`MFS_CUT_BIT])
		else $error("cutting flag dropped by interlock");

	jog_start_a: assert property (
		(o_method_flags[`MFS_JOG_BIT]
			&& pan.plus_direction_select[0] && !o_axis_run[0])
			|=> o_axis_run[0] && o_axis_dir[0])
		else $error("jog did not start axis");

	step_hold_a: assert property (
		(o_method_flags[`MFS_INC_BIT] && o_axis_run[0]
			&& left_w[0] > 11'h001)
			|=> o_axis_run[0] || !o_method_flags[`MFS_INC_BIT])
		else $error("incremental step stopped early");

	step_len_a: assert property (
		($rose(o_axis_run[0]) && o_method_flags[`MFS_INC_BIT])
			|-> left_w[0] == $past(step_len))
		else $error("step length not loaded");

	ramp_zero_a: assert property (
		($changed(pan.rapid_select_byte[`MFS_RAPID_BIT])
			&& o_axis_run[0] && !o_method_flags[`MFS_ZRN_BIT])
			|-> ##[1:210] o_axis_rate[7:0] == 8'h00)
		else $error("rate did not ramp to zero");

	hw_amount_a: assert property (
		(pan.step_amount_select[5:4] == 2'b01)
			|=> o_hw_amount == `MFS_AMT_10)
		else $error("handwheel amount decode wrong");

	ref_dir_a: assert property (
		(o_method_flags[`MFS_ZRN_BIT] && !o_axis_run[0]
			&& pan.minus_direction_select[0])
			|=> o_axis_dir[0] == $past(i_ref_dir[0]))
		else $error("reference direction not from parameter");

	ref_set_a: assert property (
		(ref_set[0] && !ref_clr[0]) |=> o_ref_end[0])
		else $error("end flag not set on completion");

	ref_clr_a: assert property (
		(i_estop || i_servo_alarm) |=> o_ref_end == 8'h00)
		else $error("end flags not cleared by stop");

	decel_rate_a: assert property (
		(o_method_flags[`MFS_ZRN_BIT] && pan.decel_byte[0]
			&& o_axis_run[0] && $stable(o_method_flags))
			|=> o_axis_rate[7:0] == `MFS_APPR_RATE
			|| !o_axis_run[0])
		else $error("decel did not give approach rate");

	jog_run_c: cover property (
		o_method_flags[`MFS_JOG_BIT] && o_axis_run[0]);
	step_done_c: cover property (
		o_method_flags[`MFS_INC_BIT] && $fell(o_axis_run[0]));
	ramp_c: cover property (
		$changed(pan.rapid_select_byte[`MFS_RAPID_BIT])
		&& o_axis_run[0]);
	ref_end_c: cover property (o_ref_end[0]);
endmodule : mfs_manual_feed

// ---- rtl/mfs_sync.sv ----
// two-stage synchroniser for the PLC input bytes
`timescale 1ns/10ps
module mfs_sync (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire mfs_pkg::mfs_panel_type i_d,
	output mfs_pkg::mfs_panel_type     o_q
);
	import mfs_pkg::*;
	mfs_sync_type q;
	mfs_sync_type next_q;
	// first stage feeds only the second stage
	always_comb begin
		next_q    = q;
		next_q.s1 = i_d;
		next_q.s2 = q.s1;
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) q <= '0;
		else       q <= next_q;
	end
	assign o_q = q.s2;
endmodule : mfs_sync

// ---- shared/mfs_consts.svh ----
// named constants for the manual feed and status flag block
`ifndef MFS_CONSTS_SVH
`define MFS_CONSTS_SVH
// ----------------------------------------------------------------
// flag byte field positions
// ----------------------------------------------------------------
`define MFS_CUT_BIT    6
`define MFS_RAPID_BIT  7
`define MFS_JOG_BIT    2
`define MFS_HW_BIT     1
`define MFS_INC_BIT    0
`define MFS_ZRN_BIT    7
`define MFS_ONE_HOT    8'h01
// ----------------------------------------------------------------
// feed rates in rate units, ramp slope per clock
// ----------------------------------------------------------------
`define MFS_JOG_RATE   8'h40
`define MFS_RAPID_RATE 8'hC8
`define MFS_APPR_RATE  8'h10
`define MFS_RAMP_DEC   8'h01
// ----------------------------------------------------------------
// incremental steps in least input increments
// ----------------------------------------------------------------
`define MFS_STEP_X10   11'h00A
`define MFS_STEP_X100  11'h064
`define MFS_STEP_X1000 11'h3E8
// ----------------------------------------------------------------
// handwheel / single-step amounts in micrometres
// ----------------------------------------------------------------
`define MFS_AMT_1      10'h001
`define MFS_AMT_10     10'h00A
`define MFS_AMT_100    10'h064
`define MFS_AMT_1000   10'h3E8
`define MFS_TICK_DIV   8'h19
`endif

// ---- shared/mfs_pkg.sv ----
// types shared by the manual feed and status flag block
package mfs_pkg;
	// operation method; value n lights flag bit n
	typedef enum logic [2:0] {
		MFS_INC = 3'h0, MFS_HW  = 3'h1, MFS_JOG = 3'h2, MFS_MDI = 3'h3,
		MFS_RMT = 3'h4, MFS_MEM = 3'h5, MFS_EDT = 3'h6, MFS_ZRN = 3'h7
	} mfs_method_type;
	typedef enum logic [1:0] {
		MFS_AX_IDLE = 2'b00, MFS_AX_RUN = 2'b01, MFS_AX_RAMP = 2'b11
	} mfs_ax_st_type;
	// PLC input bytes, bit addressed
	typedef struct packed {
		logic [7:0] plus_direction_select;
		logic [7:0] minus_direction_select;
		logic [7:0] rapid_select_byte;
		logic [7:0] step_amount_select;
		logic [7:0] decel_byte;
	} mfs_panel_type;
	// per-axis reference events from the motion core
	typedef struct packed {
		logic [4:0] manual_done;
		logic [4:0] auto_done;
		logic [4:0] check_done;
		logic [4:0] in_pos;
		logic [4:0] off_ref;
	} mfs_ref_ev_type;
	typedef struct packed {
		mfs_panel_type s2;
		mfs_panel_type s1;
	} mfs_sync_type;
	typedef struct packed {
		mfs_ax_st_type st;
		logic          dir;
		logic [7:0]    rate;
		logic [10:0]   left;
		logic          sel_q;
		logic          rapid_q;
	} mfs_axis_type;
	typedef struct packed {
		logic [7:0] operation_method_flags;
		logic [7:0] cutting_feed_state;
		logic [7:0] ref_return_end_flags;
		logic [9:0] hw_amt;
		logic       rapid_sel;
		logic [7:0] div;
		logic       tick;
	} mfs_top_type;
endpackage : mfs_pkg

// ---- testbench/mfs_manual_feed_tb.sv ----
// self-checking bench for the manual feed and status flag block
`timescale 1ns/10ps
module mfs_manual_feed_tb;
	import mfs_pkg::*;
	localparam logic [7:0] TDIV = 8'h02;
	logic           i_clk         = 1'b0;
	logic           i_rst         = 1'b1;
	mfs_method_type i_method      = MFS_INC;
	logic [5:0]     i_feed_kind   = 6'h00;
	logic           i_dwell       = 1'b0;
	logic           i_interlock   = 1'b0;
	mfs_ref_ev_type i_ref_ev      = '0;
	logic [4:0]     i_ref_dir     = 5'h1F;
	logic           i_estop       = 1'b0;
	logic           i_servo_alarm = 1'b0;
	mfs_panel_type  panel;
	logic [7:0]     o_method_flags;
	logic [7:0]     o_cut_state;
	logic [7:0]     o_ref_end;
	logic [9:0]     o_hw_amount;
	logic           o_rapid_ovr_sel;
	logic [3:0]     o_axis_run;
	logic [3:0]     o_axis_dir;
	logic [31:0]    o_axis_rate;
	int             bad_count     = 0;
	int             checks        = 0;
	int             cycles        = 0;
	// ----------------------------------------
	// clock, partner and design
	// ----------------------------------------
	always #20 i_clk = ~i_clk;
	mfs_plc_model u_mfs_plc_model (.o_panel(panel));
	// short tick so the longest step stays a few thousand clocks
	mfs_manual_feed #(.TICK_DIV(TDIV)) u_mfs_manual_feed (
		.i_clk(i_clk), .i_rst(i_rst), .i_method(i_method),
		.i_feed_kind(i_feed_kind), .i_dwell(i_dwell),
		.i_interlock(i_interlock), .i_panel(panel),
		.i_ref_ev(i_ref_ev), .i_ref_dir(i_ref_dir),
		.i_estop(i_estop), .i_servo_alarm(i_servo_alarm),
		.o_method_flags(o_method_flags), .o_cut_state(o_cut_state),
		.o_ref_end(o_ref_end), .o_hw_amount(o_hw_amount),
		.o_rapid_ovr_sel(o_rapid_ovr_sel), .o_axis_run(o_axis_run),
		.o_axis_dir(o_axis_dir), .o_axis_rate(o_axis_rate)
	);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// inputs always move 1 ns after the edge, outputs are settled
	task step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step
	task automatic check(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	// bounded wait on axis 0 rate, then compare it
	task automatic wait_rate(input logic [7:0] v, input int lim);
		int n;
		n = 0;
		while (o_axis_rate[7:0] !== v && n < lim) begin
			step(1);
			n++;
		end
		check("axis0 rate", {24'h0, o_axis_rate[7:0]}, {24'h0, v});
	endtask : wait_rate
	task wrap_up();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// hang guard, well above the few thousand clocks needed
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every method, with the feed flag toggling on the same edge
	task t_method();
		for (int m = 0; m < 8; m++) begin
			i_method = mfs_method_type'(m);
			i_feed_kind = {5'h00, m[0]};
			step(1);
			check("method", o_method_flags, 8'h01 << m);
			check("feed", o_cut_state, {m[0], 6'h00});
		end
		$display("test method done");
	endtask : t_method
	// each feed kind, then interlock held, then dwell
	task t_feed();
		for (int k = 0; k < 6; k++) begin
			i_feed_kind = 6'h01 << k;
			step(1);
			check("feed kind", o_cut_state, 8'h40);
		end
		i_interlock = 1'b1;
		step(1);
		check("feed interlock", o_cut_state, 8'h40);
		i_dwell = 1'b1;
		step(1);
		check("feed dwell", o_cut_state, 8'h00);
		{i_dwell, i_interlock, i_feed_kind} = '0;
		step(1);
		check("feed idle", o_cut_state, 8'h00);
		$display("test feed done");
	endtask : t_feed
	// edit mode refuses, jog runs while held
	task t_jog();
		i_method = MFS_EDT;
		u_mfs_plc_model.set_dir(4'h1, 4'h2);
		step(4);
		check("edit run", o_axis_run, 4'h0);
		i_method = MFS_JOG;
		step(12);
		check("jog run", o_axis_run, 4'h3);
		check("jog dir", o_axis_dir[1:0], 2'b01);
		check("jog rate", o_axis_rate[15:0], 16'h4040);
		u_mfs_plc_model.set_dir(4'h0, 4'h0);
		step(4);
		check("jog stop", o_axis_run, 4'h0);
		$display("test jog done");
	endtask : t_jog
	// rapid flip both ways ramps to zero with select held
	task t_rapid();
		u_mfs_plc_model.set_dir(4'h1, 4'h0);
		step(4);
		u_mfs_plc_model.set_rapid(1'b1);
		wait_rate(8'h00, 100);
		wait_rate(8'hC8, 20);
		check("rapid ovr", o_rapid_ovr_sel, 1'b1);
		u_mfs_plc_model.set_rapid(1'b0);
		wait_rate(8'h00, 300);
		wait_rate(8'h40, 20);
		u_mfs_plc_model.set_dir(4'h0, 4'h0);
		step(4);
		$display("test rapid done");
	endtask : t_rapid
	// one step per press for each size; first press dropped early
	task automatic t_inc();
		int n;
		int len;
		logic ok;
		i_method = MFS_INC;
		for (int k = 0; k < 3; k++) begin
			len = (k == 0) ? 10 : (k == 1) ? 100 : 1000;
			u_mfs_plc_model.set_step(8'h01 << k);
			step(1);
			u_mfs_plc_model.set_dir(4'h1, 4'h0);
			step(3);
			if (k == 0) u_mfs_plc_model.set_dir(4'h0, 4'h0);
			n = 0;
			while (o_axis_run[0] === 1'b1 && n < 2100) begin
				step(1);
				n++;
			end
			// tick phase lets the run end up to three clocks early or one clock late
			ok = (n + 3 >= len * TDIV) && (n <= len * TDIV + 1);
			check("step len", ok, 1);
			step(8);
			check("no restart", o_axis_run, 4'h0);
			u_mfs_plc_model.set_dir(4'h0, 4'h0);
			step(3);
		end
		$display("test incremental done");
	endtask : t_inc
	// amount code in handwheel mode, then code 3 as single step
	task t_amount();
		logic [9:0] amt [4];
		amt = '{10'h001, 10'h00A, 10'h064, 10'h064};
		i_method = MFS_HW;
		for (int c = 0; c < 4; c++) begin
			u_mfs_plc_model.set_step({2'b00, c[1:0], 4'h0});
			step(3);
			check("hw amount", o_hw_amount, amt[c]);
		end
		i_method = MFS_INC;
		step(2);
		check("single amount", o_hw_amount, 10'h3E8);
		$display("test amount done");
	endtask : t_amount
	// return direction, slow approach, end flag set and clear
	task t_ref();
		i_method = MFS_ZRN;
		i_ref_dir = 5'h1E;
		u_mfs_plc_model.set_dir(4'h1, 4'h0);
		step(4);
		check("ref dir", {o_axis_run[0], o_axis_dir[0]}, 2'b10);
		u_mfs_plc_model.set_decel(5'h01);
		step(3);
		check("ref slow", o_axis_rate[7:0], 8'h10);
		u_mfs_plc_model.set_dir(4'h0, 4'h0);
		i_ref_ev.manual_done = 5'h1F;
		step(1);
		check("no in pos", o_ref_end, 8'h00);
		for (int e = 0; e < 3; e++) begin
			i_ref_ev.in_pos = 5'h1F;
			case (e)
				0: i_ref_ev.manual_done = 5'h1F;
				1: i_ref_ev.auto_done = 5'h1F;
				default: i_ref_ev.check_done = 5'h1F;
			endcase
			step(1);
			i_ref_ev = '0;
			check("ref set", o_ref_end, 8'h1F);
			case (e)
				0: i_ref_ev.off_ref = 5'h1F;
				1: i_estop = 1'b1;
				default: i_servo_alarm = 1'b1;
			endcase
			step(1);
			{i_estop, i_servo_alarm} = 2'b00;
			i_ref_ev = '0;
			check("ref clear", o_ref_end, 8'h00);
		end
		$display("test reference done");
	endtask : t_ref
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		step(5);
		i_rst = 1'b0;
		step(2);
		t_method();
		t_feed();
		t_jog();
		t_rapid();
		t_inc();
		t_amount();
		t_ref();
		wrap_up();
	end
endmodule : mfs_manual_feed_tb

// ---- testbench/mfs_plc_model.sv ----
// behavioural PLC model that drives the panel input bytes
`timescale 1ns/10ps
module mfs_plc_model (
	output mfs_pkg::mfs_panel_type o_panel
);
	import mfs_pkg::*;
	// ----------------------------------------
	// panel writes, called just after an edge
	// ----------------------------------------
	// all bytes driven from time zero, never left floating
	initial o_panel = '0;
	// only axes 0 to 3 carry direction bits
	task set_dir(input logic [3:0] p, input logic [3:0] m);
		o_panel.plus_direction_select = {4'h0, p};
		o_panel.minus_direction_select = {4'h0, m};
	endtask : set_dir
	// bit 7 only; direction bits may stay held
	task set_rapid(input logic b);
		o_panel.rapid_select_byte = {b, 7'h00};
	endtask : set_rapid
	// step size in bits 0-2, amount code in 5:4
	task set_step(input logic [7:0] b);
		o_panel.step_amount_select = b;
	endtask : set_step
	// per-axis approach slow-down bits
	task set_decel(input logic [4:0] b);
		o_panel.decel_byte = {3'h0, b};
	endtask : set_decel
endmodule : mfs_plc_model
